//--- core/fsl_params.svh
// Timing constants for the fieldbus state and indicator controller.
`ifndef FSL_PARAMS_SVH
`define FSL_PARAMS_SVH
`define FSL_CLK_KHZ 40000
`define FSL_FAST_MS 50
`define FSL_PHASE_MS 200
`define FSL_PAUSE_MS 1000
`define FSL_CNT_W 26
`endif

//--- core/fsl_pkg.sv
// Types shared by the fieldbus state and indicator controller.
`include "fsl_params.svh"
package fsl_pkg;
   typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT} fsl_state_t;
   typedef enum logic [2:0] {LM_OFF, LM_ON, LM_BLINK, LM_SINGLE, LM_DOUBLE, LM_TRIPLE} fsl_led_mode_t;
   typedef struct packed {
      logic valid;
      fsl_state_t target;
   } fsl_req_t;
   typedef struct packed {
      logic [1:0] link;
      logic [1:0] act;
   } fsl_phy_t;
   typedef struct packed {
      fsl_led_mode_t mode;
      logic [2:0] step;
      logic [`FSL_CNT_W-1:0] cnt;
   } fsl_seq_t;
   typedef struct packed {
      fsl_state_t state;
      logic mbx_en;
      logic in_en;
      logic out_en;
      logic boot;
      logic restart;
      logic refuse;
      fsl_phy_t phy_s1;
      fsl_phy_t phy_s2;
      logic [`FSL_CNT_W-1:0] fast_cnt;
      logic fast_ph;
      logic [1:0] la_led;
      fsl_seq_t run;
      fsl_seq_t err;
      logic run_led;
      logic err_led;
   } fsl_regs_t;
endpackage

//--- core/fsl_ctrl.sv
// Fieldbus communication state machine with its link, run and error indicators.
//
// Notes on behaviour
// [R1] Port indicator: off, steady, 50 ms fast flash.
// [R2] Run indicator follows communication state.
// [R3] Error indicator: double, single, blink, off.
// [R4] Flash pulses 200 ms, gaps 200, pause 1000.
// [R5] Init refuses application exchanges; master configures.
// [R6] Pre-Operational: mailbox on, process data off.
// [R7] No Safe-Operational without valid data mapping.
// [R8] Safe-Operational: inputs update, outputs discarded.
// [R9] Operational: inputs delivered, outputs applied.
// [R10] Operational to Pre-Operational halts both updates.
// [R11] Safe-Operational to Init halts inputs, mailbox.
// [R12] Operational to Init halts everything.
// [R13] Neighbour transitions toggle one service each.
// [R14] Bootstrap only from Init; leaving restarts.
// [R15] Plain blink is 200 ms on, off.
`timescale 1ns/1ps
`default_nettype none
module fsl_ctrl
   import fsl_pkg::*;
#(
   parameter int unsigned FAST_CYC = `FSL_FAST_MS * `FSL_CLK_KHZ,
   parameter int unsigned PHASE_CYC = `FSL_PHASE_MS * `FSL_CLK_KHZ,
   parameter int unsigned PAUSE_CYC = `FSL_PAUSE_MS * `FSL_CLK_KHZ
) (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire fsl_req_t REQ_I,
   input wire logic MAP_VALID_I,
   input wire fsl_phy_t PHY_I,
   input wire logic WDOG_ERR_I,
   input wire logic LOCAL_ERR_I,
   input wire logic CFG_ERR_I,
   output fsl_state_t STATE_O,
   output logic MBX_EN_O,
   output logic IN_EN_O,
   output logic OUT_EN_O,
   output logic BOOT_O,
   output logic RESTART_O,
   output logic REFUSE_O,
   output logic [1:0] LA_LED_O,
   output logic RUN_LED_O,
   output logic ERR_LED_O
);
   localparam int CW = `FSL_CNT_W;
   localparam logic [CW-1:0] FAST_LAST = CW'(FAST_CYC - 1);
   localparam logic [CW-1:0] PHASE_LAST = CW'(PHASE_CYC - 1);
   localparam logic [CW-1:0] PAUSE_LAST = CW'(PAUSE_CYC - 1);

   fsl_regs_t q, d;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic legal(input fsl_state_t from, input fsl_state_t to,
                                  input logic map_ok);
      case (from)
         ST_INIT: legal = (to == ST_PREOP) || (to == ST_BOOT); // R14
         ST_PREOP: legal = (to == ST_INIT) || ((to == ST_SAFEOP) && map_ok); // R7
         ST_SAFEOP: legal = (to == ST_PREOP) || (to == ST_INIT) || (to == ST_OP);
         ST_OP: legal = (to == ST_SAFEOP) || (to == ST_PREOP) || (to == ST_INIT);
         ST_BOOT: legal = (to == ST_INIT);
         default: legal = 1'b0;
      endcase
   endfunction

   function automatic logic [2:0] final_step(input fsl_led_mode_t m);
      case (m)
         LM_DOUBLE: final_step = 3'h3;
         LM_TRIPLE: final_step = 3'h5;
         default: final_step = 3'h1;
      endcase
   endfunction

   // One flash sequence: even steps lit, odd steps dark, the last gap is the long pause except in LM_BLINK.
   function automatic fsl_seq_t seq_step(input fsl_seq_t s, input fsl_led_mode_t m);
      fsl_seq_t r;
      logic [CW-1:0] last;
      r = s;
      last = PHASE_LAST; // R4 R15
      if ((s.step == final_step(s.mode)) && (s.mode != LM_BLINK)) begin
         last = PAUSE_LAST; // R4
      end
      if (m != s.mode) begin
         r.mode = m;
         r.step = 3'h0;
         r.cnt = '0;
      end else if (s.cnt == last) begin
         r.cnt = '0;
         r.step = (s.step == final_step(s.mode)) ? 3'h0 : s.step + 3'h1;
      end else begin
         r.cnt = s.cnt + 1'b1;
      end
      return r;
   endfunction

   function automatic logic seq_led(input fsl_seq_t s);
      case (s.mode)
         LM_OFF: seq_led = 1'b0;
         LM_ON: seq_led = 1'b1;
         default: seq_led = ~s.step[0];
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      fsl_led_mode_t run_m;
      fsl_led_mode_t err_m;
      run_m = LM_OFF;
      err_m = LM_OFF;
      d = q;
      d.restart = 1'b0;
      d.refuse = 1'b0;
      d.phy_s1 = PHY_I;
      d.phy_s2 = q.phy_s1;

      // A request for the present state is accepted silently; anything unlisted is refused.
      if (REQ_I.valid && (REQ_I.target != q.state)) begin
         if (legal(q.state, REQ_I.target, MAP_VALID_I)) begin
            d.state = REQ_I.target;
            d.restart = (q.state == ST_BOOT); // R14
         end else begin
            d.refuse = 1'b1; // R7
         end
      end
      // Services follow the state alone, so every transition starts or stops exactly its own.
      d.mbx_en = (d.state == ST_PREOP) || (d.state == ST_SAFEOP) || (d.state == ST_OP); // R5 R6 R11 R12 R13
      d.in_en = (d.state == ST_SAFEOP) || (d.state == ST_OP); // R8 R10 R11 R13
      d.out_en = (d.state == ST_OP); // R8 R9 R10 R12 R13
      d.boot = (d.state == ST_BOOT); // R14

      if (q.fast_cnt == FAST_LAST) begin
         d.fast_cnt = '0;
         d.fast_ph = ~q.fast_ph; // R1
      end else begin
         d.fast_cnt = q.fast_cnt + 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         d.la_led[i] = q.phy_s2.link[i] & (~q.phy_s2.act[i] | q.fast_ph); // R1
      end

      case (q.state)
         ST_PREOP: run_m = LM_BLINK; // R2
         ST_SAFEOP: run_m = LM_SINGLE;
         ST_OP: run_m = LM_ON;
         default: run_m = LM_OFF;
      endcase
      if (WDOG_ERR_I) begin
         err_m = LM_DOUBLE; // R3
      end else if (LOCAL_ERR_I) begin
         err_m = LM_SINGLE;
      end else if (CFG_ERR_I) begin
         err_m = LM_BLINK;
      end else begin
         err_m = LM_OFF;
      end
      d.run = seq_step(q.run, run_m);
      d.err = seq_step(q.err, err_m);
      d.run_led = seq_led(d.run); // R2
      d.err_led = seq_led(d.err); // R3
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign STATE_O = q.state;
   assign MBX_EN_O = q.mbx_en;
   assign IN_EN_O = q.in_en;
   assign OUT_EN_O = q.out_en;
   assign BOOT_O = q.boot;
   assign RESTART_O = q.restart;
   assign REFUSE_O = q.refuse;
   assign LA_LED_O = q.la_led;
   assign RUN_LED_O = q.run_led;
   assign ERR_LED_O = q.err_led;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic [CW-1:0] on_len_q;
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         on_len_q <= '0;
      end else begin
         // A mode change restarts the sequence lit, so the lit run is counted afresh from it.
         on_len_q <= (RUN_LED_O && (d.run.mode == q.run.mode)) ? on_len_q + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);

   la_off_a: assert property (!q.phy_s2.link[0] |=> !LA_LED_O[0]) // R1
      else $error("port indicator lit without link");
   la_steady_a: assert property (q.phy_s2.link[1] && !q.phy_s2.act[1] |=> LA_LED_O[1]) // R1
      else $error("port indicator not steady on idle link");
   run_state_a: assert property ((STATE_O == ST_INIT |=> !RUN_LED_O) and // R2
                                 (STATE_O == ST_OP |=> RUN_LED_O))
      else $error("run indicator disagrees with state");
   err_none_a: assert property (!WDOG_ERR_I && !LOCAL_ERR_I && !CFG_ERR_I |=> !ERR_LED_O) // R3
      else $error("error indicator lit with no error");
   pulse_len_a: assert property ($fell(RUN_LED_O) && $stable(q.run.mode) // R4 R15
                                 && q.run.mode != LM_OFF |-> on_len_q == PHASE_LAST + 1'b1)
      else $error("run flash pulse length wrong");
   init_quiet_a: assert property (STATE_O == ST_INIT |-> !MBX_EN_O && !IN_EN_O && !OUT_EN_O) // R5
      else $error("service active in init");
   preop_svc_a: assert property (STATE_O == ST_PREOP |-> MBX_EN_O && !IN_EN_O && !OUT_EN_O) // R6
      else $error("pre-operational services wrong");
   map_hold_a: assert property (STATE_O == ST_PREOP && REQ_I.valid // R7
                                && REQ_I.target == ST_SAFEOP && !MAP_VALID_I
                                |=> STATE_O == ST_PREOP && REFUSE_O)
      else $error("advanced without valid mapping");
   safeop_svc_a: assert property (STATE_O == ST_SAFEOP |-> IN_EN_O && !OUT_EN_O) // R8
      else $error("safe-operational services wrong");
   op_svc_a: assert property (STATE_O == ST_OP |-> IN_EN_O && OUT_EN_O && MBX_EN_O) // R9
      else $error("operational services wrong");
   op_down_a: assert property ($past(STATE_O) == ST_OP && STATE_O != ST_OP // R10 R12
                               |-> !OUT_EN_O)
      else $error("outputs still updating after leaving operational");
   to_init_a: assert property ($past(STATE_O) inside {ST_SAFEOP, ST_OP} // R11 R12 R13
                               && STATE_O == ST_INIT |-> !IN_EN_O && !MBX_EN_O)
      else $error("services active after return to init");
   boot_gate_a: assert property (REQ_I.valid && REQ_I.target == ST_BOOT // R14
                                 && STATE_O != ST_INIT && STATE_O != ST_BOOT |=> !BOOT_O)
      else $error("bootstrap entered from wrong state");
   restart_a: assert property ($past(STATE_O) == ST_BOOT && STATE_O == ST_INIT // R14
                               |-> RESTART_O ##1 !RESTART_O)
      else $error("restart pulse missing on bootstrap exit");

   reach_op_c: cover property (STATE_O == ST_SAFEOP ##1 STATE_O == ST_OP);
   refuse_c: cover property (REFUSE_O);
   boot_exit_c: cover property (RESTART_O);
   double_c: cover property (q.err.mode == LM_DOUBLE && q.err.step == 3'h3);
endmodule
`default_nettype wire

//--- bench/fsl_master.sv
// Behavioural fieldbus master that issues state requests and presents the data mapping.
`timescale 1ns/1ps
`default_nettype none
module fsl_master
   import fsl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic go_i,
   input wire fsl_state_t tgt_i,
   input wire logic map_i,
   output var fsl_req_t req_o,
   output var logic map_valid_o
);
   // Illegal targets are forwarded as commanded, because a real master may send them too.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         req_o <= '0;
         map_valid_o <= 1'b0;
      end else begin
         req_o <= '{valid: go_i, target: tgt_i};
         map_valid_o <= map_i;
      end
   end
endmodule
`default_nettype wire

//--- bench/fsl_ctrl_tb.sv
// Self-checking bench for the fieldbus state and indicator controller.
`timescale 1ns/1ps
`default_nettype none
module fsl_ctrl_tb;
   import fsl_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic go = 1'b0;
   fsl_state_t tgt = ST_INIT;
   logic map = 1'b0;
   fsl_phy_t phy = '0;
   logic [2:0] errs = 3'h0;
   fsl_req_t req;
   logic map_v, mbx, ien, oen, boot, rst_p, refu, run, err;
   fsl_state_t st;
   fsl_state_t exp_st = ST_INIT;
   fsl_state_t prev_st = ST_INIT;
   logic [1:0] la;
   logic [8:0] notes[$];
   int mismatches = 0;
   int samples_checked = 0;
   wire logic [3:0] leds = {la, err, run};
   fsl_state_t seq[20] = '{ST_PREOP, ST_SAFEOP, ST_SAFEOP, ST_OP, ST_PREOP, ST_SAFEOP, ST_INIT,
      ST_BOOT, ST_OP, ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_INIT, ST_PREOP, ST_OP, ST_SAFEOP,
      ST_OP, ST_SAFEOP, ST_PREOP};
   initial forever #12.5 clk = ~clk;
   fsl_master i_master(.clk_i(clk), .rstn_i(rstn), .go_i(go), .tgt_i(tgt), .map_i(map),
      .req_o(req), .map_valid_o(map_v));
   fsl_ctrl #(.FAST_CYC(4), .PHASE_CYC(8), .PAUSE_CYC(40)) i_dut(.CORE_CLK_I(clk),
      .RSTN_I(rstn), .REQ_I(req), .MAP_VALID_I(map_v), .PHY_I(phy), .WDOG_ERR_I(errs[2]),
      .LOCAL_ERR_I(errs[1]), .CFG_ERR_I(errs[0]), .STATE_O(st), .MBX_EN_O(mbx),
      .IN_EN_O(ien), .OUT_EN_O(oen), .BOOT_O(boot), .RESTART_O(rst_p), .REFUSE_O(refu),
      .LA_LED_O(la), .RUN_LED_O(run), .ERR_LED_O(err));
   function automatic logic [8:0] outs(fsl_state_t s, logic rs, logic r);
      case (s)
         ST_PREOP: return {s, 4'h8, rs, r};
         ST_SAFEOP: return {s, 4'hC, rs, r};
         ST_OP: return {s, 4'hE, rs, r};
         ST_BOOT: return {s, 4'h1, rs, r};
         default: return {s, 4'h0, rs, r};
      endcase
   endfunction
   function automatic logic legal(fsl_state_t f, fsl_state_t t, logic m);
      case (f)
         ST_INIT: return t == ST_PREOP || t == ST_BOOT;
         ST_PREOP: return t == ST_INIT || (t == ST_SAFEOP && m);
         ST_SAFEOP, ST_OP: return t != ST_BOOT;
         default: return t == ST_INIT;
      endcase
   endfunction
   task automatic check(logic [8:0] seen, logic [8:0] want);
      samples_checked++;
      if (seen !== want) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Each request is judged against the state the earlier ones leave behind.
   task automatic request(fsl_state_t t, logic m);
      @(posedge clk);
      go <= 1'b1;
      tgt <= t;
      map <= m;
      if (t != exp_st) begin
         if (legal(exp_st, t, m)) begin
            notes.push_back(outs(t, exp_st == ST_BOOT, 1'b0));
            exp_st = t;
         end else
            notes.push_back(outs(exp_st, 1'b0, 1'b1));
      end
   endtask
   task automatic idle(int n);
      @(posedge clk);
      go <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // The count is four-state so that an unknown indicator turns into a mismatch.
   task automatic lit(int sel, int n, int want);
      logic [8:0] c;
      c = 9'h0;
      repeat (n) begin
         @(negedge clk);
         c = c + 9'(leds[sel]);
      end
      check(c, 9'(want));
      // Return on a rising edge so that the caller's next drive lands on one.
      @(posedge clk);
   endtask
   always @(negedge clk) begin
      if (rstn && (st !== prev_st || refu === 1'b1 || rst_p === 1'b1))
         check({st, mbx, ien, oen, boot, rst_p, refu}, notes.size() > 0 ? notes.pop_front() : 'x);
      prev_st = st;
   end
   initial begin
      #(25 * 20000);
      mismatches++;
      conclude();
   end
   initial begin
      void'($urandom(90314));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      check({st, mbx, ien, oen, boot, rst_p, refu}, 9'h0);
      check(9'(leds), 9'h0);
      foreach (seq[i]) request(seq[i], i != 1);
      idle(5);
      lit(0, 32, 16);
      request(ST_SAFEOP, 1'b1);
      idle(5);
      lit(0, 48, 8);
      request(ST_OP, 1'b1);
      idle(5);
      lit(0, 20, 20);
      for (int i = 0; i < 80; i++) begin
         request(fsl_state_t'($urandom % 5), 1'($urandom % 2));
         if ($urandom % 2)
            idle(0);
      end
      request(ST_INIT, 1'b1);
      idle(5);
      lit(0, 20, 0);
      errs <= 3'h6;
      idle(4);
      lit(1, 64, 16);
      errs <= 3'h3;
      idle(4);
      lit(1, 48, 8);
      errs <= 3'h1;
      idle(4);
      lit(1, 32, 16);
      errs <= 3'h0;
      idle(4);
      lit(1, 20, 0);
      phy <= 4'h4;
      idle(5);
      lit(2, 8, 8);
      lit(3, 8, 0);
      phy <= 4'hE;
      idle(5);
      lit(2, 8, 8);
      lit(3, 8, 4);
      check(9'(notes.size()), 9'h0);
      conclude();
   end
endmodule
`default_nettype wire
